// [include/card_tx_pkg.sv]
// Shared constants and types for the card data clock/data transmitter.
package card_tx_pkg;

  // ==========================================================================
  // Timebase
  // ==========================================================================
  localparam int CLK_MHZ           = 250;
  localparam int STROBE_DELAY_MS   = 12;
  localparam int STROBE_DELAY_CYC  = STROBE_DELAY_MS * 1000 * CLK_MHZ;
  localparam int BIT_PERIOD_US     = 320;
  localparam int BIT_PERIOD_CYC    = BIT_PERIOD_US * CLK_MHZ;
  localparam int DATA_SETUP_US     = 100;
  localparam int DATA_SETUP_CYC    = DATA_SETUP_US * CLK_MHZ;
  localparam int CLOCK_LOW_US      = 100;
  localparam int CLOCK_LOW_CYC     = CLOCK_LOW_US * CLK_MHZ;

  // ==========================================================================
  // Character and message layout
  // ==========================================================================
  localparam int         DIGIT_W        = 4;
  localparam int         CHAR_BITS      = 5;
  localparam int         FIFO_DEPTH     = 32;
  localparam logic [3:0] START_CHAR     = 4'h0_00B;
  localparam logic [3:0] END_CHAR       = 4'h0_00F;
  localparam logic [3:0] SEP_LOW        = 4'h0_000;
  localparam logic [3:0] SEP_HIGH       = 4'h0_001;
  localparam logic [31:0] LAYOUT1_CONST = 32'h1A21_0001;
  localparam logic [31:0] FAC4_MAX      = 32'h0000_9999;
  localparam logic [23:0] USER5_MAX     = 24'h09_9999;
  localparam logic [4:0] LAST_IDX_SEP   = 5'h0_01C;
  localparam logic [4:0] LAST_IDX_ZERO  = 5'h0_01D;
  localparam logic [4:0] LAST_IDX_SHORT = 5'h0_00B;

  typedef enum logic [1:0] {
    LAYOUT_CONST_SEP,
    LAYOUT_ZERO_CONST,
    LAYOUT_SHORT
  } layout_e;

  // Facility: eight BCD digits, user: six BCD digits, most significant high.
  typedef struct packed {
    logic [31:0] facility;
    logic [23:0] user;
  } ident_s;

  typedef struct packed {
    logic       last;
    logic [4:0] bits;
  } char_word_s;

  typedef struct packed {
    logic dataO;
    logic dataOe;
    logic clkO;
    logic clkOe;
    logic strobeO;
    logic strobeOe;
  } pins_s;

endpackage

// [rtl/card_data_clock_serial_tx.sv]
// Identification record transmitter on an open-drain clock/data/strobe link.
// What this block does
// - Data, clock and strobe are open-drain: pulled low when asserted, else released.
// - All three lines are active low, so a data one, an active clock and an asserted strobe are low.
// - Each data bit is set up before and stays valid across the falling clock edge.
// - With the strobe enabled, the first data bit follows strobe assertion by 12 ms.
// - Every bit takes one clock period of 320 us.
// - The strobe stays asserted 12 ms after the last data bit before release.
// - Each character is a BCD digit sent low bit first, then its odd parity bit.
// - Messages begin with start character B and end with end character F.
// - The check character is the XOR of all characters from start through end.
// - The constant-and-separator layout pads, sends B, 1A210001, four facility digits, 0, 1, six user digits, F, check and pads.
// - That layout saturates facility at 9999 and passes user through unchanged, up to 999999.
// - The zero-constant layout pads, sends B, seven zeros, eight facility digits, six user digits, F, check and pads.
// - That layout takes facility up to 99999999 and user up to 999999.
// - The short layout sends B, four low user digits, the fifth user digit, four facility digits, F and check, unpadded.
`timescale 1ns/1ps
module card_data_clock_serial_tx
  import card_tx_pkg::*;
#(
  parameter int STROBE_CYC = card_tx_pkg::STROBE_DELAY_CYC,
  parameter int PERIOD_CYC = card_tx_pkg::BIT_PERIOD_CYC,
  parameter int SETUP_CYC  = card_tx_pkg::DATA_SETUP_CYC,
  parameter int LOW_CYC    = card_tx_pkg::CLOCK_LOW_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire card_tx_pkg::layout_e layout,
  input  wire logic                 strobeEnable,
  input  wire logic                 reqValid,
  input  wire card_tx_pkg::ident_s  reqIdent,
  output logic                      reqReady,
  output logic                      busy,
  output card_tx_pkg::pins_s        linePins
);
  import card_tx_pkg::*;

  localparam logic [31:0] STROBE_T = 32'(STROBE_CYC - 1);
  localparam logic [31:0] SETUP_T  = 32'(SETUP_CYC - 1);
  localparam logic [31:0] LOW_T    = 32'(LOW_CYC - 1);
  localparam logic [31:0] HIGH_T   = 32'(PERIOD_CYC - SETUP_CYC - LOW_CYC - 1);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rstMeta_n;
  logic rstSync_n;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ==========================================================================
  // Message composer
  // ==========================================================================
  typedef enum logic {C_IDLE, C_RUN} comp_state_e;

  comp_state_e cState;
  comp_state_e next_cState;
  logic [4:0]  idx;
  logic [4:0]  next_idx;
  logic [31:0] fac;
  logic [31:0] next_fac;
  logic [23:0] user;
  logic [23:0] next_user;
  layout_e     lay;
  layout_e     next_lay;
  logic [3:0]  chk;
  logic [3:0]  next_chk;
  logic        next_reqReady;
  logic [3:0]  nib;
  logic        isPad;
  logic        isCheck;
  logic        isLast;
  logic [4:0]  encBits;
  logic        pushValid;
  logic        pushReady;
  char_word_s  pushWord;
  logic        popValid;
  logic        popReady;
  char_word_s  popWord;

  function automatic logic [3:0] digitOf(logic [31:0] v, logic [4:0] k);
    return v[k[2:0]*4 +: 4];
  endfunction

  // Character at the current position, most significant digit first except the fifth user digit, sent after the low four in the short layout.
  always_comb
  begin
    nib     = 4'h0_000;
    isPad   = 1'b0;
    isCheck = 1'b0;
    isLast  = 1'b0;
    case (lay)
      LAYOUT_CONST_SEP:
      begin
        isLast = idx == LAST_IDX_SEP;
        if (idx < 5'd3 || idx > 5'd25)
          isPad = 1'b1;
        else if (idx == 5'd3)
          nib = START_CHAR;
        else if (idx <= 5'd11)
          nib = digitOf(LAYOUT1_CONST, 5'(5'd11 - idx));
        else if (idx <= 5'd15)
          nib = digitOf(fac, 5'(5'd15 - idx));
        else if (idx == 5'd16)
          nib = SEP_LOW;
        else if (idx == 5'd17)
          nib = SEP_HIGH;
        else if (idx <= 5'd23)
          nib = digitOf({8'h00, user}, 5'(5'd23 - idx));
        else if (idx == 5'd24)
          nib = END_CHAR;
        else
          isCheck = 1'b1;
      end
      LAYOUT_ZERO_CONST:
      begin
        isLast = idx == LAST_IDX_ZERO;
        if (idx < 5'd3 || idx > 5'd26)
          isPad = 1'b1;
        else if (idx == 5'd3)
          nib = START_CHAR;
        else if (idx <= 5'd10)
          nib = 4'h0_000;
        else if (idx <= 5'd18)
          nib = digitOf(fac, 5'(5'd18 - idx));
        else if (idx <= 5'd24)
          nib = digitOf({8'h00, user}, 5'(5'd24 - idx));
        else if (idx == 5'd25)
          nib = END_CHAR;
        else
          isCheck = 1'b1;
      end
      default:
      begin
        isLast = idx == LAST_IDX_SHORT;
        if (idx == 5'd0)
          nib = START_CHAR;
        else if (idx <= 5'd4)
          nib = digitOf({8'h00, user}, 5'(5'd4 - idx));
        else if (idx == 5'd5)
          nib = digitOf({8'h00, user}, 5'd4);
        else if (idx <= 5'd9)
          nib = digitOf(fac, 5'(5'd9 - idx));
        else if (idx == 5'd10)
          nib = END_CHAR;
        else
          isCheck = 1'b1;
      end
    endcase
  end

  char_enc #(.DIGIT_W(DIGIT_W)) u_enc (
    .digit    (isCheck ? chk : nib),
    .charBits (encBits)
  );

  assign pushValid     = cState == C_RUN;
  assign pushWord.last = isLast;
  assign pushWord.bits = isPad ? 5'h0_000 : encBits;

  always_comb
  begin
    next_cState   = cState;
    next_idx      = idx;
    next_fac      = fac;
    next_user     = user;
    next_lay      = lay;
    next_chk      = chk;
    case (cState)
      C_IDLE:
      begin
        // Nothing is taken while the handshake shows the composer busy.
        if (reqValid && reqReady)
        begin
          next_cState = C_RUN;
          next_idx    = 5'h0_000;
          next_chk    = 4'h0_000;
          next_lay    = layout;
          next_fac    = reqIdent.facility;
          next_user   = reqIdent.user;
          if (layout != LAYOUT_ZERO_CONST && reqIdent.facility > FAC4_MAX)
            next_fac = FAC4_MAX;
          if (layout == LAYOUT_SHORT && reqIdent.user > USER5_MAX)
            next_user = USER5_MAX;
        end
      end
      C_RUN:
      begin
        if (pushReady)
        begin
          next_idx = idx + 5'd1;
          if (!isPad && !isCheck)
            next_chk = chk ^ nib;
          if (isLast)
            next_cState = C_IDLE;
        end
      end
      default: next_cState = C_IDLE;
    endcase
    next_reqReady = next_cState == C_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      cState   <= C_IDLE;
      idx      <= '0;
      fac      <= '0;
      user     <= '0;
      lay      <= LAYOUT_CONST_SEP;
      chk      <= '0;
      reqReady <= 1'b0;
    end
    else
    begin
      cState   <= next_cState;
      idx      <= next_idx;
      fac      <= next_fac;
      user     <= next_user;
      lay      <= next_lay;
      chk      <= next_chk;
      reqReady <= next_reqReady;
    end
  end

  // ==========================================================================
  // Character buffer
  // ==========================================================================
  // The composer outruns the line by far; it stalls here when the buffer fills.
  char_fifo #(.W($bits(char_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .inValid   (pushValid),
    .inReady   (pushReady),
    .inData    (pushWord),
    .outValid  (popValid),
    .outReady  (popReady),
    .outData   (popWord)
  );

  // ==========================================================================
  // Line serializer
  // ==========================================================================
  typedef enum logic [2:0] {
    S_IDLE, S_LEAD, S_SETUP, S_LOW, S_HIGH, S_TAIL
  } ser_state_e;

  ser_state_e sState;
  ser_state_e next_sState;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [4:0]  shreg;
  logic [4:0]  next_shreg;
  logic [2:0]  bitCnt;
  logic [2:0]  next_bitCnt;
  logic        lastWord;
  logic        next_lastWord;
  logic        useStrobe;
  logic        next_useStrobe;
  pins_s       next_pins;
  logic        next_busy;
  logic        wordDone;

  assign wordDone = bitCnt == 3'd4;
  assign popReady = (sState == S_IDLE) ||
                    (sState == S_HIGH && timer == '0 && wordDone && !lastWord);

  always_comb
  begin
    next_sState    = sState;
    next_timer     = (timer != '0) ? timer - 32'd1 : timer;
    next_shreg     = shreg;
    next_bitCnt    = bitCnt;
    next_lastWord  = lastWord;
    next_useStrobe = useStrobe;
    next_pins      = linePins;
    next_pins.dataO   = 1'b0;
    next_pins.clkO    = 1'b0;
    next_pins.strobeO = 1'b0;
    case (sState)
      S_IDLE:
      begin
        if (popValid)
        begin
          next_shreg     = popWord.bits;
          next_lastWord  = popWord.last;
          next_bitCnt    = 3'd0;
          next_useStrobe = strobeEnable;
          if (strobeEnable)
          begin
            next_sState        = S_LEAD;
            next_timer         = STROBE_T;
            next_pins.strobeOe = 1'b1;
          end
          else
          begin
            next_sState      = S_SETUP;
            next_timer       = SETUP_T;
            next_pins.dataOe = popWord.bits[0];
          end
        end
      end
      S_LEAD:
      begin
        if (timer == '0)
        begin
          next_sState      = S_SETUP;
          next_timer       = SETUP_T;
          next_pins.dataOe = shreg[0];
        end
      end
      S_SETUP:
      begin
        if (timer == '0)
        begin
          next_sState     = S_LOW;
          next_timer      = LOW_T;
          next_pins.clkOe = 1'b1;
        end
      end
      S_LOW:
      begin
        if (timer == '0)
        begin
          next_sState     = S_HIGH;
          next_timer      = HIGH_T;
          next_pins.clkOe = 1'b0;
        end
      end
      S_HIGH:
      begin
        if (timer == '0)
        begin
          if (!wordDone)
          begin
            next_sState      = S_SETUP;
            next_timer       = SETUP_T;
            next_bitCnt      = bitCnt + 3'd1;
            next_shreg       = {1'b0, shreg[4:1]};
            next_pins.dataOe = shreg[1];
          end
          else if (lastWord)
          begin
            next_pins.dataOe = 1'b0;
            next_sState      = useStrobe ? S_TAIL : S_IDLE;
            next_timer       = STROBE_T;
          end
          else if (popValid)
          begin
            next_sState      = S_SETUP;
            next_timer       = SETUP_T;
            next_bitCnt      = 3'd0;
            next_shreg       = popWord.bits;
            next_lastWord    = popWord.last;
            next_pins.dataOe = popWord.bits[0];
          end
        end
      end
      S_TAIL:
      begin
        if (timer == '0)
        begin
          next_sState        = S_IDLE;
          next_pins.strobeOe = 1'b0;
        end
      end
      default: next_sState = S_IDLE;
    endcase
    next_busy = next_sState != S_IDLE || next_cState != C_IDLE || popValid;
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      sState    <= S_IDLE;
      timer     <= '0;
      shreg     <= '0;
      bitCnt    <= '0;
      lastWord  <= 1'b0;
      useStrobe <= 1'b0;
      linePins  <= '0;
      busy      <= 1'b0;
    end
    else
    begin
      sState    <= next_sState;
      timer     <= next_timer;
      shreg     <= next_shreg;
      bitCnt    <= next_bitCnt;
      lastWord  <= next_lastWord;
      useStrobe <= next_useStrobe;
      linePins  <= next_pins;
      busy      <= next_busy;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync_n);

  logic [31:0] sinceStrobe;
  logic [31:0] sinceClk;

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      sinceStrobe <= '0;
      sinceClk    <= '0;
    end
    else
    begin
      sinceStrobe <= (next_pins.strobeOe && !linePins.strobeOe) ?
                     32'd0 : sinceStrobe + 32'd1;
      sinceClk    <= (next_pins.clkOe && !linePins.clkOe) ?
                     32'd0 : sinceClk + 32'd1;
    end
  end

  sequence clkFall;
    $rose(linePins.clkOe);
  endsequence

  a_open_drain: assert property (
    !linePins.dataO && !linePins.clkO && !linePins.strobeO)
    else $error("open-drain line driven high");
  a_data_hold: assert property (
    clkFall |-> $stable(linePins.dataOe) ##1 $stable(linePins.dataOe))
    else $error("data moved at falling clock edge");
  // The phases run to many thousand cycles, so they are timed by counters.
  a_low_phase: assert property (
    $fell(linePins.clkOe) |-> sinceClk == 32'(LOW_CYC))
    else $error("clock low phase has wrong length");
  a_bit_period: assert property (
    next_pins.clkOe && !linePins.clkOe && bitCnt != 3'd0 |->
      sinceClk == 32'(PERIOD_CYC - 1))
    else $error("bit period differs from nominal");
  a_strobe_covers: assert property (
    linePins.clkOe && useStrobe |-> linePins.strobeOe)
    else $error("clock active without strobe");
  a_strobe_lead: assert property (
    sState == S_LEAD && timer == '0 |->
      sinceStrobe == 32'(STROBE_CYC - 1))
    else $error("strobe lead time wrong");
  a_strobe_tail: assert property (
    $fell(linePins.strobeOe) |->
      sinceClk == 32'(PERIOD_CYC - SETUP_CYC + STROBE_CYC))
    else $error("strobe tail time wrong");
  a_char_parity: assert property (
    pushValid && pushReady && !isPad |-> ^pushWord.bits)
    else $error("character parity not odd");
  a_start_char: assert property (
    pushValid && pushReady && !isPad && !isCheck && $past(cState) == C_IDLE
      |-> nib == START_CHAR)
    else $error("message does not open with start character");
endmodule // card_data_clock_serial_tx

// [rtl/char_enc.sv]
// BCD digit to five-bit character with odd parity.
`timescale 1ns/1ps
module char_enc #(
  parameter int DIGIT_W = 4
) (
  input  wire logic [DIGIT_W-1:0] digit,
  output logic      [DIGIT_W:0]   charBits
);
  // Bit 0 goes out first; the parity bit last makes the count of ones odd.
  assign charBits = {~^digit, digit};
endmodule // char_enc

// [rtl/char_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module char_fifo #(
  parameter int W     = 6,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         rstSync_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr;
  logic [AW:0]  rdPtr;
  logic [AW:0]  next_wrPtr;
  logic [AW:0]  next_rdPtr;
  logic         doWrite;

  assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign outData  = mem[rdPtr[AW-1:0]];
  assign doWrite  = inValid && inReady;

  always_comb
  begin
    next_wrPtr = wrPtr + (AW+1)'(doWrite);
    next_rdPtr = rdPtr + (AW+1)'(outValid && outReady);
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // Storage has no reset; only words behind the write pointer are read.
  always_ff @(posedge clk_sys)
  begin
    if (doWrite)
      mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule // char_fifo

// [tb/term_rx_model.sv]
// Terminal-side receiver model: samples the open-drain link and times it.
`timescale 1ns/1ps
module term_rx_model (
  input wire logic               clk_sys,
  input wire card_tx_pkg::pins_s linePins
);
  import card_tx_pkg::*;
  // ==========================================================================
  // Wire levels with pull-ups
  // ==========================================================================
  logic dataLine;
  logic clkLine;
  logic strbLine;
  logic clkPrev = 1'b1;
  logic strbPrev = 1'b1;
  logic dataPrev = 1'b1;
  logic bits[$];
  int   cnt = 0;
  int   lastFall;
  int   strbFall;
  int   lead;
  int   tail;
  int   minPer;
  int   maxPer;
  int   faults = 0;
  assign dataLine = !linePins.dataOe;
  assign clkLine  = !linePins.clkOe;
  assign strbLine = !linePins.strobeOe;
  task automatic clear();
    bits.delete();
    lastFall = -1;
    lead = -1;
    tail = -1;
    minPer = 1_000_000;
    maxPer = 0;
  endtask
  initial clear();
  // ==========================================================================
  // Sampling on the falling clock line
  // ==========================================================================
  always @(posedge clk_sys)
  begin
    cnt++;
    if (linePins.dataO || linePins.clkO || linePins.strobeO)
      faults++;
    if (!strbLine && strbPrev)
    begin
      strbFall = cnt;
      lastFall = -1;
    end
    if (!clkLine && clkPrev)
    begin
      bits.push_back(!dataLine);
      // Without a strobe there is no lead time to measure.
      if (lastFall < 0)
      begin
        if (!strbLine)
          lead = cnt - strbFall;
      end
      else
      begin
        minPer = (cnt - lastFall < minPer) ? cnt - lastFall : minPer;
        maxPer = (cnt - lastFall > maxPer) ? cnt - lastFall : maxPer;
      end
      lastFall = cnt;
    end
    // A data change while the clock is low would corrupt the sample.
    if (!clkLine && !clkPrev && dataLine != dataPrev)
      faults++;
    if (strbLine && !strbPrev)
      tail = cnt - lastFall;
    clkPrev = clkLine;
    strbPrev = strbLine;
    dataPrev = dataLine;
  end
endmodule // term_rx_model

// [tb/testbench.sv]
// Self-checking bench for the identification record transmitter.
`timescale 1ns/1ps
module testbench;
  import card_tx_pkg::*;
  localparam int ST = 40;
  localparam int PER = 24;
  localparam int SU = 6;
  typedef struct {
    layout_e     lay;
    logic        stb;
    logic [31:0] fac;
    logic [23:0] usr;
    logic [31:0] facX;
    logic [23:0] usrX;
  } row_s;
  logic    clk_sys;
  logic    rst_n;
  logic    strobeEnable;
  logic    reqValid;
  logic    reqReady;
  logic    busy;
  layout_e layout;
  ident_s  reqIdent;
  pins_s   linePins;
  logic    expBits[$];
  logic [3:0] lrc;
  int      err_count = 0;
  int      n_checks = 0;
  row_s rows[5] = '{
    '{LAYOUT_CONST_SEP, 1, 32'h0000_1234, 24'h56_7890, 32'h0000_1234,
      24'h56_7890},
    '{LAYOUT_CONST_SEP, 0, 32'h0001_2345, 24'h99_9999, 32'h0000_9999,
      24'h99_9999},
    '{LAYOUT_ZERO_CONST, 1, 32'h9876_5432, 24'h00_0001, 32'h9876_5432,
      24'h00_0001},
    '{LAYOUT_SHORT, 1, 32'h0000_0563, 24'h00_3551, 32'h0000_0563,
      24'h00_3551},
    '{LAYOUT_SHORT, 0, 32'h0001_0000, 24'h12_3456, 32'h0000_9999,
      24'h09_9999}
  };
  card_data_clock_serial_tx #(
    .STROBE_CYC (ST),
    .PERIOD_CYC (PER),
    .SETUP_CYC  (SU),
    .LOW_CYC    (6)
  ) u_card_data_clock_serial_tx (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .layout       (layout),
    .strobeEnable (strobeEnable),
    .reqValid     (reqValid),
    .reqIdent     (reqIdent),
    .reqReady     (reqReady),
    .busy         (busy),
    .linePins     (linePins)
  );
  term_rx_model u_term_rx_model (
    .clk_sys  (clk_sys),
    .linePins (linePins)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic waitUntil(input bit idle, input int lim);
    int k;
    k = 0;
    while ((idle ? busy !== 1'b0 : reqReady !== 1'b1) && k < lim)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= lim)
    begin
      err_count++;
      $display("[FAIL] %0t wait limit reached", $time);
      tally_and_finish();
    end
  endtask
  task automatic putc(input logic [3:0] d);
    for (int i = 0; i < 4; i++)
      expBits.push_back(d[i]);
    expBits.push_back(~^d);
    lrc ^= d;
  endtask
  task automatic pad();
    repeat (15) expBits.push_back(1'b0);
  endtask
  task automatic build(input row_s r);
    logic [3:0] c;
    lrc = 4'h0;
    if (r.lay != LAYOUT_SHORT)
      pad();
    putc(START_CHAR);
    case (r.lay)
      LAYOUT_CONST_SEP:
      begin
        for (int i = 7; i >= 0; i--) putc(LAYOUT1_CONST[i*4+:4]);
        for (int i = 3; i >= 0; i--) putc(r.facX[i*4+:4]);
        putc(SEP_LOW);
        putc(SEP_HIGH);
        for (int i = 5; i >= 0; i--) putc(r.usrX[i*4+:4]);
      end
      LAYOUT_ZERO_CONST:
      begin
        repeat (7) putc(4'h0);
        for (int i = 7; i >= 0; i--) putc(r.facX[i*4+:4]);
        for (int i = 5; i >= 0; i--) putc(r.usrX[i*4+:4]);
      end
      default:
      begin
        for (int i = 3; i >= 0; i--) putc(r.usrX[i*4+:4]);
        putc(r.usrX[19:16]);
        for (int i = 3; i >= 0; i--) putc(r.facX[i*4+:4]);
      end
    endcase
    putc(END_CHAR);
    c = lrc;
    putc(c);
    if (r.lay != LAYOUT_SHORT)
      pad();
  endtask
  task automatic send(input row_s r);
    waitUntil(0, 5000);
    layout = r.lay;
    strobeEnable = r.stb;
    reqIdent = '{r.fac, r.usr};
    reqValid = 1'b1;
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
  endtask
  task automatic runRow(input row_s r, input int n);
    u_term_rx_model.clear();
    expBits.delete();
    repeat (n) build(r);
    repeat (n) send(r);
    waitUntil(1, 40000);
    repeat (4) @(posedge clk_sys);
    check(u_term_rx_model.bits.size(), expBits.size());
    foreach (expBits[i])
      check(u_term_rx_model.bits[i], expBits[i]);
    check(u_term_rx_model.minPer, PER);
    check(u_term_rx_model.maxPer, PER);
    check(u_term_rx_model.lead, r.stb ? ST + SU : -1);
    check(u_term_rx_model.tail, r.stb ? PER - SU + ST : -1);
    check(u_term_rx_model.faults, 0);
  endtask
  task automatic doReset(input int n);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b0;
    #1;
    check(32'(linePins), 0);
    check(reqReady, 0);
    check(busy, 0);
    repeat (n) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(reqReady, 0);
    @(posedge clk_sys);
    #1;
    check(reqReady, 1);
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    layout = LAYOUT_CONST_SEP;
    strobeEnable = 1'b1;
    reqIdent = '0;
    doReset(12);
    foreach (rows[i])
      runRow(rows[i], 1);
    // Two full messages overflow the 32-word buffer and stall the composer.
    runRow(rows[0], 2);
    send(rows[2]);
    repeat (300) @(posedge clk_sys);
    doReset(3);
    runRow(rows[3], 1);
    tally_and_finish();
  end
  initial
  begin
    #360_000;
    err_count++;
    $display("[FAIL] %0t run time limit reached", $time);
    tally_and_finish();
  end
endmodule // testbench
